//--- common/rcs_map.svh
// Offsets, field positions, reset values and counts of the reset sequencer
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH

`define RCS_ADDR_W 4
`define RCS_OFF_CFG_WORD 4'h0
`define RCS_OFF_STATUS 4'h4
`define RCS_OFF_CTRL 4'h8

`define RCS_CFG_DLL_DIS_BIT 0
`define RCS_CFG_CMH_LSB 1
`define RCS_CFG_RESET 32'h00000000

`define RCS_CTRL_TICK_SEL_RESET 2'h0

`define RCS_CFG_PHASE_CLKS 12'h400
`define RCS_PLL_LOCK_REFS 12'h320
`define RCS_DLL_LOCK_BUS 12'hC01
`define RCS_HRST_HOLD_BUS 12'h200
`define RCS_SRST_DELAY_BUS 12'h003

`endif

//--- common/rcs_pkg.sv
// Types of the reset and configuration sequencer
package rcs_pkg;

	typedef enum logic [2:0] {
		RCS_ST_POR,
		RCS_ST_CONFIG,
		RCS_ST_PLL,
		RCS_ST_DLL,
		RCS_ST_HRST,
		RCS_ST_SRST,
		RCS_ST_RUN
	} rcs_state_e;

	typedef enum logic [1:0] {
		RCS_RATIO_INT,
		RCS_RATIO_2P5,
		RCS_RATIO_3P5
	} rcs_ratio_e;

	typedef struct packed {
		logic read;
		logic write;
		logic [3:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} rcs_av_req_s;

	typedef struct packed {
		logic [2:0] clock_mode_straps;
		logic host_port_enable_strap;
		logic reset_cfg_role_strap;
	} rcs_straps_s;

	typedef struct packed {
		logic t1;
		logic t2;
		logic t3;
		logic t4;
	} rcs_ticks_s;

	typedef struct packed {
		rcs_state_e st;
		logic [11:0] cnt;
		logic por_q;
		logic host_mode;
		logic cfg_slave;
		logic [2:0] mode_straps;
		rcs_ratio_e ratio;
		logic [31:0] cfg_word;
		logic [3:0] byte_done;
		logic [1:0] tick_sel;
		logic [7:0] phase;
		logic clk_en;
		logic hard_n;
		logic soft_n;
		logic bus_clk;
		rcs_ticks_s ticks;
		logic upm_launch;
		logic sdram_launch;
		logic waitreq;
		logic [31:0] rdata;
	} rcs_state_s;

endpackage

//--- rtl/rcs_sequencer.sv
// Power-on reset and reset configuration sequencer with memory controller tick generator
`timescale 1ns/10ps
`include "rcs_map.svh"

// Notes on behaviour
// - Host enable and role straps sampled on power-on reset rising edge
// - Host enable strap high selects host configuration
// - Host mode: configuration waits for full word
// - Hard reset held 512 bus clocks after lock
// - Soft reset released three bus clocks later
// - Host enable strap low selects hardware configuration
// - Role strap high slave, low master
// - Both resets asserted until hard reset hold ends
// - Configuration lasts 1024 clocks, then sample mode straps
// - Halt until system PLL locks, ratio from mode
// - PLL lock takes 800 reference clocks
// - Internal clocks enabled only after PLL lock
// - DLL locks after PLL unless disabled
// - DLL disable bit skips DLL locking
// - Bus outputs launched on bus clock rising edge
// - Four ticks per bus cycle, T1 rise, T3 fall
// - T2, T4 placed by clock ratio class
// - Chip-select machines launch on programmed tick
// - SDRAM machine launches only on T1
module rcs_sequencer #(
	parameter int BUS_DIV = 20,
	parameter logic [31:0] HW_CFG_WORD = 32'h00000000
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic power_on_reset_n,
	input rcs_pkg::rcs_straps_s straps,
	input wire logic reference_clock_tick,
	input rcs_pkg::rcs_av_req_s av_req,
	output logic av_waitrequest,
	output logic [31:0] av_readdata,
	output logic hard_reset_n,
	output logic soft_reset_n,
	output logic clocks_enable,
	output logic config_slave,
	output logic host_mode,
	output logic bus_ref_clock,
	output rcs_pkg::rcs_ticks_s mc_ticks,
	output logic upm_launch,
	output logic sdram_launch
);
	import rcs_pkg::*;

	localparam logic [7:0] DIV = 8'(BUS_DIV);
	localparam logic [7:0] HALF = 8'(BUS_DIV / 2);

	rcs_state_s s_reg;
	rcs_state_s s_next;
	logic bus_tick;
	logic req;
	logic [7:0] t2_pos;
	logic [7:0] t4_pos;
	logic [31:0] status_word;
	logic cfg_open;
	logic is_read;
	logic is_write;
	logic por_rise;
	logic cfg_all_bytes;
	logic [31:0] rd_mux;

	// Tick positions within a bus cycle by ratio class
	always_comb begin
		case (s_reg.ratio)
			RCS_RATIO_2P5: begin
				t2_pos = 8'((BUS_DIV * 3) / 10);
				t4_pos = 8'((BUS_DIV * 8) / 10);
			end

			RCS_RATIO_3P5: begin
				t2_pos = 8'((BUS_DIV * 4) / 14);
				t4_pos = 8'((BUS_DIV * 11) / 14);
			end

			default: begin
				t2_pos = 8'(BUS_DIV / 4);
				t4_pos = 8'((BUS_DIV * 3) / 4);
			end
		endcase
	end

	assign is_read = av_req.read;
	assign is_write = av_req.write;

	assign bus_tick = s_reg.clk_en && (s_reg.phase == 8'h00);
	assign req = (is_read || is_write) && s_reg.waitreq;
	assign por_rise = power_on_reset_n && !s_reg.por_q;
	assign cfg_all_bytes = &s_reg.byte_done;
	// Host may write the word only after release and before the PLL locks
	assign cfg_open = s_reg.host_mode && ((s_reg.st == RCS_ST_CONFIG) || (s_reg.st == RCS_ST_PLL));

	always_comb begin
		status_word = 32'h00000000;
		status_word[0] = s_reg.host_mode;
		status_word[1] = s_reg.cfg_slave;
		status_word[2] = s_reg.hard_n;
		status_word[3] = s_reg.soft_n;
		status_word[4] = s_reg.clk_en;
		status_word[7:5] = s_reg.mode_straps;
		status_word[11:8] = s_reg.byte_done;
		status_word[14:12] = s_reg.st;
	end

	// Read data selection by offset
	always_comb begin
		case (av_req.address)
			`RCS_OFF_CFG_WORD: begin
				rd_mux = s_reg.cfg_word;
			end

			`RCS_OFF_STATUS: begin
				rd_mux = status_word;
			end

			`RCS_OFF_CTRL: begin
				rd_mux = {30'h00000000, s_reg.tick_sel};
			end

			default: begin
				rd_mux = 32'h00000000;
			end
		endcase
	end

	always_comb begin
		s_next = s_reg;
		s_next.por_q = power_on_reset_n;

		s_next.waitreq = 1'b1;
		s_next.upm_launch = 1'b0;
		s_next.sdram_launch = 1'b0;
		s_next.ticks = '0;

		// Bus clock and tick generation once clocks run
		if (s_reg.clk_en) begin
			if (s_reg.phase == DIV - 8'h01) begin
				s_next.phase = 8'h00;
			end else begin
				s_next.phase = s_reg.phase + 8'h01;
			end
			s_next.bus_clk = (s_next.phase < HALF);

			s_next.ticks.t1 = (s_next.phase == 8'h00);
			s_next.ticks.t2 = (s_next.phase == t2_pos);
			s_next.ticks.t3 = (s_next.phase == HALF);
			s_next.ticks.t4 = (s_next.phase == t4_pos);

			case (s_reg.tick_sel)
				2'h0: begin
					s_next.upm_launch = s_next.ticks.t1;
				end

				2'h1: begin
					s_next.upm_launch = s_next.ticks.t2;
				end

				2'h2: begin
					s_next.upm_launch = s_next.ticks.t3;
				end

				default: begin
					s_next.upm_launch = s_next.ticks.t4;
				end
			endcase
			s_next.sdram_launch = s_next.ticks.t1;
		end

		// Register access
		if (req) begin
			s_next.waitreq = 1'b0;

			s_next.rdata = 32'h00000000;
			if (is_read) begin
				s_next.rdata = rd_mux;
			end else begin
				case (av_req.address)
					`RCS_OFF_CFG_WORD: begin
						if (cfg_open) begin
							for (int i = 0; i < 4; i++) begin
								if (av_req.byteenable[i]) begin
									s_next.cfg_word[i*8 +: 8] = av_req.writedata[i*8 +: 8];
									s_next.byte_done[i] = 1'b1;
								end
							end
						end
					end
					`RCS_OFF_CTRL: begin
						s_next.tick_sel = av_req.writedata[1:0];
					end

					default: begin
						s_next.tick_sel = s_reg.tick_sel;
					end
				endcase
			end
		end

		// Sequencer
		case (s_reg.st)
			RCS_ST_POR: begin
				s_next.hard_n = 1'b0;
				s_next.soft_n = 1'b0;
				s_next.cnt = 12'h000;
				if (por_rise) begin
					s_next.host_mode = straps.host_port_enable_strap;
					s_next.cfg_slave = straps.reset_cfg_role_strap;
					if (straps.host_port_enable_strap) begin
						s_next.cfg_word = `RCS_CFG_RESET;
					end else begin
						s_next.cfg_word = HW_CFG_WORD;
					end
					s_next.byte_done = 4'h0;
					s_next.st = RCS_ST_CONFIG;
				end
			end

			RCS_ST_CONFIG: begin
				if (s_reg.cnt != `RCS_CFG_PHASE_CLKS) begin
					s_next.cnt = s_reg.cnt + 12'h001;
				end
				// Host mode stretches the phase until every byte lane is written
				if ((s_reg.cnt == `RCS_CFG_PHASE_CLKS) && (!s_reg.host_mode || cfg_all_bytes)) begin
					s_next.mode_straps = straps.clock_mode_straps;
					case ({s_reg.cfg_word[`RCS_CFG_CMH_LSB], straps.clock_mode_straps[1:0]})
						3'h2: begin
							s_next.ratio = RCS_RATIO_2P5;
						end

						3'h3: begin
							s_next.ratio = RCS_RATIO_3P5;
						end

						default: begin
							s_next.ratio = RCS_RATIO_INT;
						end
					endcase
					s_next.cnt = 12'h000;
					s_next.st = RCS_ST_PLL;
				end
			end

			RCS_ST_PLL: begin
				if (reference_clock_tick) begin
					s_next.cnt = s_reg.cnt + 12'h001;
				end
				if (s_reg.cnt == `RCS_PLL_LOCK_REFS) begin
					s_next.clk_en = 1'b1;
					s_next.phase = DIV - 8'h01;
					s_next.cnt = 12'h000;
					if (s_reg.cfg_word[`RCS_CFG_DLL_DIS_BIT]) begin
						s_next.st = RCS_ST_HRST;
					end else begin
						s_next.st = RCS_ST_DLL;
					end
				end
			end

			RCS_ST_DLL: begin
				if (bus_tick) begin
					s_next.cnt = s_reg.cnt + 12'h001;
				end
				if (s_reg.cnt == `RCS_DLL_LOCK_BUS) begin
					s_next.cnt = 12'h000;
					s_next.st = RCS_ST_HRST;
				end
			end

			RCS_ST_HRST: begin
				if (bus_tick) begin
					s_next.cnt = s_reg.cnt + 12'h001;
				end
				if (s_reg.cnt == `RCS_HRST_HOLD_BUS) begin
					s_next.hard_n = 1'b1;
					s_next.cnt = 12'h000;
					s_next.st = RCS_ST_SRST;
				end
			end

			RCS_ST_SRST: begin
				if (bus_tick) begin
					s_next.cnt = s_reg.cnt + 12'h001;
				end
				if (s_reg.cnt == `RCS_SRST_DELAY_BUS) begin
					s_next.soft_n = 1'b1;
					s_next.st = RCS_ST_RUN;
				end
			end

			RCS_ST_RUN: begin
				s_next.cnt = 12'h000;
			end

			default: begin
				s_next.st = RCS_ST_POR;
				s_next.hard_n = 1'b0;
				s_next.soft_n = 1'b0;
			end
		endcase

		// External reset low restarts the whole sequence
		if (!power_on_reset_n) begin
			s_next.st = RCS_ST_POR;
			s_next.hard_n = 1'b0;
			s_next.soft_n = 1'b0;

			s_next.clk_en = 1'b0;
			s_next.bus_clk = 1'b0;
			s_next.phase = 8'h00;
			s_next.cnt = 12'h000;

			s_next.ticks = '0;
			s_next.upm_launch = 1'b0;
			s_next.sdram_launch = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '{
				st: RCS_ST_POR,
				cnt: 12'h000,
				por_q: 1'b0,
				host_mode: 1'b0,
				cfg_slave: 1'b0,
				mode_straps: 3'h0,
				ratio: RCS_RATIO_INT,
				cfg_word: `RCS_CFG_RESET,
				byte_done: 4'h0,
				tick_sel: `RCS_CTRL_TICK_SEL_RESET,
				phase: 8'h00,
				clk_en: 1'b0,
				hard_n: 1'b0,
				soft_n: 1'b0,
				bus_clk: 1'b0,
				ticks: '0,
				upm_launch: 1'b0,
				sdram_launch: 1'b0,
				waitreq: 1'b1,
				rdata: 32'h00000000
			};
		end else begin
			s_reg <= s_next;
		end
	end

	assign av_waitrequest = s_reg.waitreq;
	assign av_readdata = s_reg.rdata;
	assign hard_reset_n = s_reg.hard_n;
	assign soft_reset_n = s_reg.soft_n;

	assign clocks_enable = s_reg.clk_en;
	assign config_slave = s_reg.cfg_slave;
	assign host_mode = s_reg.host_mode;

	assign bus_ref_clock = s_reg.bus_clk;
	assign mc_ticks = s_reg.ticks;
	assign upm_launch = s_reg.upm_launch;
	assign sdram_launch = s_reg.sdram_launch;

endmodule

//--- sim/rcs_board.sv
// Board and host side model: straps and reference clock ticks
`timescale 1ns/10ps
module rcs_board (
	input wire logic clk,
	input wire logic host_en,
	input wire logic role,
	output rcs_pkg::rcs_straps_s straps,
	output logic ref_tick
);
	import rcs_pkg::*;
	logic [1:0] div_reg = 2'h0;
	always @(posedge clk) begin
		div_reg <= div_reg + 2'h1;
		ref_tick <= (div_reg == 2'h3);
	end
	assign straps = {3'h0, host_en, host_en | role};
endmodule

//--- sim/rcs_chk.sv
// Port checks of the reset sequencer
`timescale 1ns/10ps
module rcs_chk #(
	parameter int BUS_DIV = 20
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic power_on_reset_n,
	input wire logic hard_reset_n,
	input wire logic soft_reset_n,
	input wire logic clocks_enable,
	input wire logic bus_ref_clock,
	input rcs_pkg::rcs_ticks_s mc_ticks,
	input wire logic sdram_launch
);
	import rcs_pkg::*;
	localparam int Q = BUS_DIV / 4;
	localparam int H = BUS_DIV / 2;
	localparam int S0 = 3 * BUS_DIV - 1;
	localparam int S1 = 3 * BUS_DIV + 1;
	logic [16:0] en_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) en_reg <= 17'h0;
		else en_reg <= clocks_enable ? en_reg + 17'h1 : 17'h0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n || !power_on_reset_n);
	property p_por; disable iff (!arst_n) !power_on_reset_n |=> !hard_reset_n && !soft_reset_n; endproperty
	a_por: assert property (p_por) else $error("reset not held");
	property p_clk; hard_reset_n |-> clocks_enable; endproperty
	a_clk: assert property (p_clk) else $error("clocks off");
	property p_t1; $rose(bus_ref_clock) |-> mc_ticks.t1; endproperty
	a_t1: assert property (p_t1) else $error("t1 off edge");
	property p_t3; mc_ticks.t1 |-> ##H mc_ticks.t3 && !bus_ref_clock; endproperty
	a_t3: assert property (p_t3) else $error("t3 off");
	property p_t2; mc_ticks.t1 |-> ##[Q:H] mc_ticks.t2; endproperty
	a_t2: assert property (p_t2) else $error("t2 off");
	property p_sd; sdram_launch |-> mc_ticks.t1; endproperty
	a_sd: assert property (p_sd) else $error("sdram tick");
	property p_soft; $rose(hard_reset_n) |-> ##[S0:S1] $rose(soft_reset_n); endproperty
	a_soft: assert property (p_soft) else $error("soft delay");
	property p_hold; $rose(hard_reset_n) |-> en_reg inside {[511 * BUS_DIV:513 * BUS_DIV],
		[3584 * BUS_DIV:3586 * BUS_DIV]}; endproperty
	a_hold: assert property (p_hold) else $error("hard hold");
endmodule
bind rcs_sequencer rcs_chk #(.BUS_DIV(BUS_DIV)) u_chk (.clk(clk), .arst_n(arst_n),
	.power_on_reset_n(power_on_reset_n), .hard_reset_n(hard_reset_n), .soft_reset_n(soft_reset_n),
	.clocks_enable(clocks_enable), .bus_ref_clock(bus_ref_clock), .mc_ticks(mc_ticks), .sdram_launch(sdram_launch));

//--- sim/tb_top.sv
// Testbench of the reset sequencer
`timescale 1ns/10ps
`include "rcs_map.svh"
module tb_top;
	import rcs_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic power_on_reset_n = 1'b0;
	logic host_en = 1'b0;
	logic role = 1'b1;
	logic ref_tick, av_waitrequest, hard_reset_n, soft_reset_n, clocks_enable, config_slave, host_mode;
	logic bus_ref_clock, upm_launch, sdram_launch;
	logic [31:0] av_readdata;
	rcs_straps_s straps;
	rcs_av_req_s av_req = '0;
	rcs_ticks_s mc_ticks;
	int n_mismatch = 0;
	int cmp_count = 0;
	always #2 clk = ~clk;
	rcs_board u_board (.clk(clk), .host_en(host_en), .role(role), .straps(straps), .ref_tick(ref_tick));
	rcs_sequencer #(.BUS_DIV(8)) DUT (.clk(clk), .arst_n(arst_n), .power_on_reset_n(power_on_reset_n),
		.straps(straps), .reference_clock_tick(ref_tick), .av_req(av_req), .av_waitrequest(av_waitrequest),
		.av_readdata(av_readdata), .hard_reset_n(hard_reset_n), .soft_reset_n(soft_reset_n),
		.clocks_enable(clocks_enable), .config_slave(config_slave), .host_mode(host_mode),
		.bus_ref_clock(bus_ref_clock), .mc_ticks(mc_ticks), .upm_launch(upm_launch), .sdram_launch(sdram_launch));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q);
		@(posedge clk);
		av_req <= {!w, w, a, d, be};
		do @(posedge clk); while (av_waitrequest !== 1'b0);
		q = av_readdata;
		av_req <= '0;
	endtask
	task automatic por(input logic h, input logic r);
		@(posedge clk);
		power_on_reset_n <= 1'b0;
		host_en <= h;
		role <= r;
		repeat (16) @(posedge clk);
		chk("por_resets", 0, {hard_reset_n, soft_reset_n});
		power_on_reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		role <= !r;
		repeat (2) @(posedge clk);
		chk("host_mode", h, host_mode);
		chk("slave", h | r, config_slave);
	endtask
	task automatic seq(input int hold, input int lo);
		int n;
		n = 0;
		while (clocks_enable !== 1'b1) begin
			@(posedge clk);
			n++;
		end
		chk("lock_wait", 1, n > lo);
		chk("resets_at_lock", 0, {hard_reset_n, soft_reset_n});
		n = 0;
		while (hard_reset_n !== 1'b1) begin
			@(posedge clk);
			n++;
		end
		chk("hard_hold", 1, n >= hold - 8 && n <= hold + 8);
		n = 0;
		while (soft_reset_n !== 1'b1) begin
			@(posedge clk);
			n++;
		end
		chk("soft_delay", 1, n >= 23 && n <= 25);
	endtask
	task automatic host_cfg;
		logic [31:0] q;
		por(1'b1, 1'b0);
		repeat (1500) @(posedge clk);
		chk("held", 0, clocks_enable);
		for (int i = 0; i < 4; i++) bus(1'b1, `RCS_OFF_CFG_WORD, 32'hA5C35A01, 4'h1 << i, q);
		bus(1'b0, `RCS_OFF_CFG_WORD, 32'h0, 4'hF, q);
		chk("cfg_word", 32'hA5C35A01, q);
		bus(1'b0, 4'hC, 32'h0, 4'hF, q);
		chk("unmapped", 0, q);
		seq(4096, 3150);
	endtask
	task automatic ticks;
		logic [31:0] q;
		int n;
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, `RCS_OFF_CTRL, 32'(s), 4'hF, q);
			repeat (2) @(posedge clk);
			do @(posedge clk); while (upm_launch !== 1'b1);
			chk("upm_tick", 4'h8 >> s, mc_ticks);
		end
		do @(posedge clk); while (sdram_launch !== 1'b1);
		chk("sdram_tick", 32'h11, {mc_ticks, bus_ref_clock});
		n = 0;
		for (int k = 0; k < 3; k++) begin
			do begin
				@(posedge clk);
				n++;
			end while (mc_ticks[2 - k] !== 1'b1);
			chk("tick_pos", 2 * k + 2, n);
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		por(1'b0, 1'b0);
		seq(28680, 4200);
		host_cfg;
		ticks;
		wrap_up;
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		wrap_up;
	end
endmodule
